// >>> hw/rgc_top.sv
// Functional notes
// - No forced PWM: PWM at 600 mA and up, else PFM.
// - Forced PWM: fixed frequency PWM at any load.
// - Voltage, PWM, limit, slew and delays reset from OTP.
// - Measurement select write latches buck, starts measurement.
// - Measured buck forced to PWM; at most 50 us.
// - Measurement end sets done flag; mask blocks event.
// - Result bits 7..0 in first word, bit 8 in second.
// - Result is 20 mA per code; all ones is 10.22 A.
// - Dither on both bucks only with its bit set, sync off.
// - Sync off: RC, no events; sync on: follows valid clock.
// - Sync flag raises no event while masked.
// - Five bit nominal external clock, 1 to 24 MHz.
// - External clock valid within -30 to +10 percent.
// - No valid clock at OTP-to-standby or at a buck turning on in standby sets flag.
// - After OTP load enter standby; host may rewrite settings.
// - Enables act only in standby or active.
// - Pin select 0: enable bit switches regulator.
// - Enable bit and pin select 1: pin decides.
// - Pin mode: rise delay after pin rise, fall delay after fall.
// - Delays apply to pin transitions only.
// - On regulator drives its voltage code; bit 0 keeps off.
`timescale 1ns/1ps
module rgc_top #(
    parameter int OTP_LOAD_CYCLES   = rgc_pkg::OTP_LOAD_CYC,
    parameter int DELAY_STEP_CYCLES = rgc_pkg::DELAY_STEP_CYC
) (
    input  logic                      ref_clk,
    input  logic                      srst,
    input  logic                      enable_pin,
    input  logic                      sync_clock_input,
    input  rgc_pkg::rgc_buck_cfg_s [1:0] otp_buck_cfg,
    input  rgc_pkg::rgc_lin_cfg_s  [1:0] otp_lin_cfg,
    input  logic [1:0]                buck_cfg_write,
    input  rgc_pkg::rgc_buck_cfg_s [1:0] buck_cfg_data,
    input  logic [1:0]                lin_cfg_write,
    input  rgc_pkg::rgc_lin_cfg_s  [1:0] lin_cfg_data,
    input  logic [1:0]                buck_on_request,
    input  logic [1:0]                buck_pin_select,
    input  logic [1:0]                linreg_on_request,
    input  logic [1:0]                linreg_pin_select,
    input  logic                      dither_enable,
    input  logic                      sync_enable,
    input  logic [rgc_pkg::NOM_W-1:0] ext_clock_nominal,
    input  logic                      meas_select_write,
    input  logic                      meas_select_buck,
    input  logic                      meas_done_mask,
    input  logic                      meas_done_clear,
    input  logic                      sync_clock_mask,
    input  logic                      sync_clock_clear,
    input  logic [1:0][rgc_pkg::RESULT_W-1:0] buck_load_code,
    output rgc_pkg::rgc_mode_e        op_mode,
    output rgc_pkg::rgc_buck_cfg_s [1:0] buck_cfg,
    output rgc_pkg::rgc_lin_cfg_s  [1:0] lin_cfg,
    output logic [1:0]                buck_on,
    output logic [1:0]                linreg_on,
    output logic [1:0][rgc_pkg::VBUCK_W-1:0] buck_voltage_code,
    output logic [1:0][rgc_pkg::VLIN_W-1:0]  linreg_voltage_code,
    output logic [1:0]                buck_pwm,
    output logic                      dither_active,
    output logic                      ext_clock_valid,
    output logic                      ext_clock_selected,
    output logic                      meas_busy,
    output logic                      meas_buck,
    output logic [7:0]                meas_result_low,
    output logic [7:0]                meas_result_high,
    output logic                      meas_done_flag,
    output logic                      meas_done_event,
    output logic                      sync_clock_flag,
    output logic                      sync_clock_event
);
    import rgc_pkg::*;

    typedef struct packed {
        logic                             pin_s1;
        logic                             pin_s2;
        logic                             pin_prev;
        logic                             clk_s1;
        logic                             clk_s2;
        logic                             clk_prev;
        rgc_mode_e                        mode;
        logic [31:0]                      otp_cnt;
        logic [31:0]                      tick_cnt;
        logic                             tick;
        rgc_buck_cfg_s [NUM_BUCK-1:0]     bcfg;
        rgc_lin_cfg_s  [NUM_LIN-1:0]      lcfg;
        logic                             m_busy;
        logic                             m_buck;
        logic [31:0]                      m_cnt;
        logic [RESULT_W-1:0]              result;
        logic                             m_flag;
        logic                             s_flag;
        logic                             valid_prev;
        logic [NUM_BUCK-1:0][VBUCK_W-1:0] vbuck;
        logic [NUM_LIN-1:0][VLIN_W-1:0]   vlin;
        logic [NUM_BUCK-1:0]              pwm;
        logic                             dither;
        logic                             ext_sel;
    } rgc_top_state_s;

    rgc_top_state_s st;
    rgc_top_state_s next_st;

    logic                         clk_valid;
    logic                         clk_rise;
    logic                         allow;
    logic [NUM_CH-1:0]            ch_on;
    logic [NUM_CH-1:0]            ch_reg_en;
    logic [NUM_CH-1:0]            ch_pin_sel;
    logic [NUM_CH-1:0][DLY_W-1:0] ch_rise;
    logic [NUM_CH-1:0][DLY_W-1:0] ch_fall;
    logic                         m_set;
    logic                         s_set;
    logic                         buck_heavy;

    // Pins and sync clock are asynchronous; the second stage feeds logic
    assign clk_rise = st.clk_s2 && !st.clk_prev;
    assign allow    = (st.mode != ST_OTP_LOAD);

    // Channel order: bucks first, then the linear regulators
    always_comb begin
        ch_reg_en  = {linreg_on_request, buck_on_request};
        ch_pin_sel = {linreg_pin_select, buck_pin_select};
        for (int i = 0; i < NUM_BUCK; i++) begin
            ch_rise[i] = st.bcfg[i].rise;
            ch_fall[i] = st.bcfg[i].fall;
        end
        for (int i = 0; i < NUM_LIN; i++) begin
            ch_rise[NUM_BUCK+i] = st.lcfg[i].rise;
            ch_fall[NUM_BUCK+i] = st.lcfg[i].fall;
        end
    end

    // One delay sequencer per regulator, all sharing the pin and timebase
    rgc_chan_if ch_if [NUM_CH] ();

    for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_ch
        assign ch_if[gi].allow     = allow;
        assign ch_if[gi].reg_en    = ch_reg_en[gi];
        assign ch_if[gi].pin_sel   = ch_pin_sel[gi];
        assign ch_if[gi].pin_level = st.pin_s2;
        assign ch_if[gi].pin_edge  = st.pin_s2 ^ st.pin_prev;
        assign ch_if[gi].tick      = st.tick;
        assign ch_if[gi].rise      = ch_rise[gi];
        assign ch_if[gi].fall      = ch_fall[gi];
        assign ch_on[gi]           = ch_if[gi].on;

        rgc_delay_chan u_chan (
            .ref_clk (ref_clk),
            .srst    (srst),
            .ch      (ch_if[gi])
        );
    end

    // Frequency window check on the synchronised clock edges
    rgc_clk_check u_clk_check (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .edge_seen (clk_rise),
        .nominal   (ext_clock_nominal),
        .valid     (clk_valid)
    );

    // Flag set terms; a set in the clear cycle still lands
    always_comb begin
        m_set = st.m_busy && (st.m_cnt == 32'(MEAS_CYC - 1));
        s_set = 1'b0;
        if (sync_enable && allow && (clk_valid != st.valid_prev)) begin
            s_set = 1'b1;
        end
        if (sync_enable && !clk_valid) begin
            if ((st.mode == ST_OTP_LOAD) &&
                (st.otp_cnt == 32'(OTP_LOAD_CYCLES - 1))) begin
                s_set = 1'b1;
            end
            if ((st.mode == ST_STANDBY) && (|ch_on[NUM_BUCK-1:0])) begin
                s_set = 1'b1;
            end
        end
    end

    // Main next-state logic
    always_comb begin
        next_st = st;
        buck_heavy = 1'b0;

        // Two-stage synchronisers and edge history
        next_st.pin_s1   = enable_pin;
        next_st.pin_s2   = st.pin_s1;
        next_st.pin_prev = st.pin_s2;
        next_st.clk_s1   = sync_clock_input;
        next_st.clk_s2   = st.clk_s1;
        next_st.clk_prev = st.clk_s2;

        // Free running delay timebase, one tick per step
        next_st.tick = 1'b0;
        if (st.tick_cnt == 32'(DELAY_STEP_CYCLES - 1)) begin
            next_st.tick_cnt = '0;
            next_st.tick     = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 32'h1;
        end

        // Operating mode sequence
        case (st.mode)
            ST_OTP_LOAD: begin
                if (st.otp_cnt == 32'(OTP_LOAD_CYCLES - 1)) begin
                    next_st.mode = ST_STANDBY;
                    next_st.bcfg = otp_buck_cfg;
                    next_st.lcfg = otp_lin_cfg;
                end else begin
                    next_st.otp_cnt = st.otp_cnt + 32'h1;
                end
            end
            ST_STANDBY: begin
                if (|ch_on) begin
                    next_st.mode = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (!(|ch_on)) begin
                    next_st.mode = ST_STANDBY;
                end
            end
            default: begin
                next_st.mode = ST_OTP_LOAD;
            end
        endcase

        // Host rewrites once out of OTP load
        if (allow) begin
            for (int i = 0; i < NUM_BUCK; i++) begin
                if (buck_cfg_write[i]) begin
                    next_st.bcfg[i] = buck_cfg_data[i];
                end
            end
            for (int i = 0; i < NUM_LIN; i++) begin
                if (lin_cfg_write[i]) begin
                    next_st.lcfg[i] = lin_cfg_data[i];
                end
            end
        end

        // Load measurement; a new select write restarts the sequence
        if (allow && meas_select_write) begin
            next_st.m_busy = 1'b1;
            next_st.m_buck = meas_select_buck;
            next_st.m_cnt  = '0;
        end else if (st.m_busy) begin
            if (m_set) begin
                next_st.m_busy = 1'b0;
                next_st.result = buck_load_code[st.m_buck];
            end else begin
                next_st.m_cnt = st.m_cnt + 32'h1;
            end
        end

        // Sticky flags, set wins over clear
        next_st.m_flag = (st.m_flag && !meas_done_clear) || m_set;
        next_st.s_flag = (st.s_flag && !sync_clock_clear) || s_set;
        next_st.valid_prev = clk_valid;

        // Regulator outputs: voltage code only while the channel is on
        for (int i = 0; i < NUM_BUCK; i++) begin
            next_st.vbuck[i] = ch_on[i] ? st.bcfg[i].vcode : '0;
            buck_heavy = (buck_load_code[i] >= PWM_ENTRY_CODE);
            next_st.pwm[i] = ch_on[i] &&
                (st.bcfg[i].fpwm || buck_heavy ||
                 (st.m_busy && (st.m_buck == i[0])));
        end
        for (int i = 0; i < NUM_LIN; i++) begin
            next_st.vlin[i] = ch_on[NUM_BUCK+i] ? st.lcfg[i].vcode : '0;
        end

        // Dither only on the RC clock; external clock taken when valid
        next_st.dither  = dither_enable && !sync_enable;
        next_st.ext_sel = sync_enable && allow && clk_valid;
    end

    // Single state register; reset loads constants only
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Output mapping
    assign op_mode             = st.mode;
    assign buck_cfg            = st.bcfg;
    assign lin_cfg             = st.lcfg;
    assign buck_on             = ch_on[NUM_BUCK-1:0];
    assign linreg_on           = ch_on[NUM_CH-1:NUM_BUCK];
    assign buck_voltage_code   = st.vbuck;
    assign linreg_voltage_code = st.vlin;
    assign buck_pwm            = st.pwm;
    assign dither_active       = st.dither;
    assign ext_clock_valid     = clk_valid;
    assign ext_clock_selected  = st.ext_sel;
    assign meas_busy           = st.m_busy;
    assign meas_buck           = st.m_buck;

    // Result split across two words, upper bits of the second read zero
    assign meas_result_low  = st.result[RESULT_LOW_W-1:0];
    assign meas_result_high = {7'h00, st.result[RESULT_MSB]};

    // Masks gate the events only; flags stay visible regardless
    assign meas_done_flag   = st.m_flag;
    assign meas_done_event  = st.m_flag && !meas_done_mask;
    assign sync_clock_flag  = st.s_flag;
    assign sync_clock_event = st.s_flag && !sync_clock_mask;
endmodule : rgc_top

// >>> pkg/rgc_pkg.sv
package rgc_pkg;
    // Clock and timing, times in their own unit, counts derived
    localparam int CLK_MHZ          = 40;
    localparam int MEAS_TIME_US     = 50;
    localparam int MEAS_CYC         = MEAS_TIME_US * CLK_MHZ;
    localparam int OTP_LOAD_US      = 1000;
    localparam int OTP_LOAD_CYC     = OTP_LOAD_US * CLK_MHZ;
    localparam int DELAY_STEP_US    = 500;
    localparam int DELAY_STEP_CYC   = DELAY_STEP_US * CLK_MHZ;
    localparam int WIN_US           = 10;
    localparam int WIN_CYC          = WIN_US * CLK_MHZ;

    // Load current coding: one code step per LOAD_LSB_MA
    localparam int LOAD_LSB_MA      = 20;
    localparam int PWM_ENTRY_MA     = 600;
    localparam int RESULT_W         = 9;
    localparam int RESULT_LOW_W     = 8;
    localparam int RESULT_MSB       = 8;
    localparam logic [RESULT_W-1:0] PWM_ENTRY_CODE =
        RESULT_W'(PWM_ENTRY_MA / LOAD_LSB_MA);

    // External clock acceptance window in percent of nominal
    localparam int CLK_LOW_PCT      = 70;
    localparam int CLK_HIGH_PCT     = 110;
    localparam int PCT_FULL         = 100;
    localparam int NOM_W            = 5;
    localparam int NOMINAL_MIN_MHZ  = 1;
    localparam int NOMINAL_MAX_MHZ  = 24;

    // Field widths and channel counts
    localparam int VBUCK_W          = 8;
    localparam int VLIN_W           = 5;
    localparam int DLY_W            = 4;
    localparam int SLEW_W           = 3;
    localparam int ILIM_W           = 2;
    localparam int NUM_BUCK         = 2;
    localparam int NUM_LIN          = 2;
    localparam int NUM_CH           = NUM_BUCK + NUM_LIN;
    localparam logic [DLY_W-1:0] DLY_LAST = 4'h1;

    typedef struct packed {
        logic [VBUCK_W-1:0] vcode;
        logic               fpwm;
        logic [ILIM_W-1:0]  ilim;
        logic [SLEW_W-1:0]  slew;
        logic [DLY_W-1:0]   rise;
        logic [DLY_W-1:0]   fall;
    } rgc_buck_cfg_s;

    typedef struct packed {
        logic [VLIN_W-1:0]  vcode;
        logic [DLY_W-1:0]   rise;
        logic [DLY_W-1:0]   fall;
    } rgc_lin_cfg_s;

    typedef enum logic [1:0] {
        ST_OTP_LOAD,
        ST_STANDBY,
        ST_ACTIVE
    } rgc_mode_e;
endpackage : rgc_pkg

// >>> pkg/rgc_chan_if.sv
`timescale 1ns/1ps
interface rgc_chan_if;
    logic                      allow;
    logic                      reg_en;
    logic                      pin_sel;
    logic                      pin_level;
    logic                      pin_edge;
    logic                      tick;
    logic [rgc_pkg::DLY_W-1:0] rise;
    logic [rgc_pkg::DLY_W-1:0] fall;
    logic                      on;

    modport ctrl (output allow, reg_en, pin_sel, pin_level, pin_edge,
                  output tick, rise, fall, input on);
    modport chan (input allow, reg_en, pin_sel, pin_level, pin_edge,
                  input tick, rise, fall, output on);
endinterface : rgc_chan_if

// >>> hw/rgc_delay_chan.sv
`timescale 1ns/1ps
module rgc_delay_chan (
    input  logic        ref_clk,
    input  logic        srst,
    rgc_chan_if.chan    ch
);
    import rgc_pkg::*;

    typedef struct packed {
        logic             on;
        logic             busy;
        logic [DLY_W-1:0] steps;
    } rgc_dly_state_s;

    rgc_dly_state_s st;
    rgc_dly_state_s next_st;
    logic [DLY_W-1:0] code;

    // Register mode acts at once, pin mode waits on the shared timebase
    always_comb begin
        next_st = st;
        code    = ch.pin_level ? ch.rise : ch.fall;
        if (!ch.allow || !ch.reg_en) begin
            next_st = '0;
        end else if (!ch.pin_sel) begin
            next_st.on   = 1'b1;
            next_st.busy = 1'b0;
        end else if (ch.pin_edge) begin
            if (code == '0) begin
                next_st.on   = ch.pin_level;
                next_st.busy = 1'b0;
            end else begin
                next_st.busy  = 1'b1;
                next_st.steps = code;
            end
        end else if (!st.busy) begin
            next_st.on = ch.pin_level;
        end else if (ch.tick) begin
            if (st.steps == DLY_LAST) begin
                next_st.busy = 1'b0;
                next_st.on   = ch.pin_level;
            end else begin
                next_st.steps = st.steps - DLY_LAST;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ch.on = st.on;
endmodule : rgc_delay_chan

// >>> hw/rgc_clk_check.sv
`timescale 1ns/1ps
module rgc_clk_check (
    input  logic                      ref_clk,
    input  logic                      srst,
    input  logic                      edge_seen,
    input  logic [rgc_pkg::NOM_W-1:0] nominal,
    output logic                      valid
);
    import rgc_pkg::*;

    typedef struct packed {
        logic [31:0] win;
        logic [9:0]  edges;
        logic        valid;
    } rgc_chk_state_s;

    rgc_chk_state_s st;
    rgc_chk_state_s next_st;
    logic [31:0] edges_pct;
    logic [31:0] lim_lo;
    logic [31:0] lim_hi;
    logic        nom_ok;

    // Edges counted over a fixed window, judged against nominal
    always_comb begin
        next_st   = st;
        edges_pct = 32'(st.edges) * 32'(PCT_FULL);
        lim_lo    = 32'(nominal) * 32'(CLK_LOW_PCT * WIN_US);
        lim_hi    = 32'(nominal) * 32'(CLK_HIGH_PCT * WIN_US);
        nom_ok    = (32'(nominal) >= 32'(NOMINAL_MIN_MHZ)) &&
                    (32'(nominal) <= 32'(NOMINAL_MAX_MHZ));
        if (edge_seen && (st.edges != '1)) begin
            next_st.edges = st.edges + 10'h001;
        end
        if (st.win == 32'(WIN_CYC - 1)) begin
            next_st.win   = '0;
            next_st.edges = '0;
            next_st.valid = nom_ok && (edges_pct >= lim_lo) &&
                            (edges_pct <= lim_hi);
        end else begin
            next_st.win = st.win + 32'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign valid = st.valid;
endmodule : rgc_clk_check

// >>> testbench/rgc_clk_src.sv
`timescale 1ns/1ps
module rgc_clk_src (
    input  logic run,
    output logic clk_out
);
    // 5 MHz burst source; parks low when stopped, phase unrelated to core
    initial begin
        clk_out = 1'b0;
        #7;
        forever begin
            #100;
            clk_out <= run ? ~clk_out : 1'b0;
        end
    end
endmodule : rgc_clk_src

// >>> testbench/rgc_top_sva.sv
`timescale 1ns/1ps
module rgc_top_sva (
    input logic               ref_clk,
    input logic               srst,
    input rgc_pkg::rgc_mode_e op_mode,
    input logic [1:0]         buck_on,
    input logic [1:0]         linreg_on,
    input logic [1:0]         buck_pwm,
    input logic               dither_enable,
    input logic               sync_enable,
    input logic               dither_active,
    input logic               meas_select_write,
    input logic               meas_busy,
    input logic               meas_buck,
    input logic               meas_done_flag,
    input logic               meas_done_mask,
    input logic               meas_done_clear,
    input logic               meas_done_event,
    input logic               sync_clock_flag,
    input logic               sync_clock_mask,
    input logic               sync_clock_event
);
    import rgc_pkg::*;
    // One clock domain
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [11:0] busy_cnt;
    // Busy length counter; a restart while busy is not exercised
    always_ff @(posedge ref_clk) begin
        if (srst || !meas_busy) busy_cnt <= '0;
        else busy_cnt <= busy_cnt + 12'h001;
    end
    // Events are the flag gated by its mask, plus dither from its enable with sync off
    property p_mev; meas_done_event == (meas_done_flag && !meas_done_mask);
    endproperty
    a_mev: assert property (p_mev) else $error("done event wrong");
    property p_sev; sync_clock_event == (sync_clock_flag && !sync_clock_mask);
    endproperty
    a_sev: assert property (p_sev) else $error("sync event wrong");
    property p_dith; dither_active == $past(dither_enable && !sync_enable);
    endproperty
    a_dith: assert property (p_dith) else $error("dither wrong");
    // Measurement checks, plus outputs off during OTP load
    property p_mst; meas_select_write && op_mode != ST_OTP_LOAD |=> meas_busy;
    endproperty
    a_mst: assert property (p_mst) else $error("no meas start");
    property p_mlen; meas_busy |-> busy_cnt < 12'(MEAS_CYC); endproperty
    a_mlen: assert property (p_mlen) else $error("meas too long");
    property p_mend; $fell(meas_busy) |-> meas_done_flag; endproperty
    a_mend: assert property (p_mend) else $error("no done flag");
    property p_mpwm; meas_busy && $past(meas_busy) && buck_on[meas_buck]
        && $past(buck_on[meas_buck]) |-> buck_pwm[meas_buck]; endproperty
    a_mpwm: assert property (p_mpwm) else $error("meas not in PWM");
    property p_off; op_mode == ST_OTP_LOAD |-> !buck_on && !linreg_on;
    endproperty
    a_off: assert property (p_off) else $error("on during load");
    property p_mstk; meas_done_flag && !meas_done_clear |=> meas_done_flag;
    endproperty
    a_mstk: assert property (p_mstk) else $error("flag dropped");
endmodule : rgc_top_sva
bind rgc_top rgc_top_sva chk_u (.*);

// >>> testbench/tb_regulator_enable_clock_control.sv
`timescale 1ns/1ps
module tb_regulator_enable_clock_control;
    import rgc_pkg::*;
    logic ref_clk, srst, enable_pin, sync_clock_input, clk_run;
    rgc_buck_cfg_s [1:0] otp_buck_cfg, buck_cfg_data, buck_cfg;
    rgc_lin_cfg_s [1:0] otp_lin_cfg, lin_cfg_data, lin_cfg;
    logic [1:0] buck_cfg_write, lin_cfg_write, buck_on_request, buck_on;
    logic [1:0] buck_pin_select, linreg_on_request, linreg_pin_select;
    logic [1:0] linreg_on, buck_pwm;
    logic dither_enable, sync_enable, meas_select_write, meas_select_buck;
    logic meas_done_mask, meas_done_clear, sync_clock_mask, sync_clock_clear;
    logic dither_active, ext_clock_valid, ext_clock_selected, meas_busy;
    logic meas_buck, meas_done_flag, meas_done_event;
    logic sync_clock_flag, sync_clock_event;
    logic [4:0] ext_clock_nominal;
    logic [1:0][8:0] buck_load_code;
    logic [1:0][7:0] buck_voltage_code;
    logic [1:0][4:0] linreg_voltage_code;
    logic [7:0] meas_result_low, meas_result_high;
    logic [8:0] code;
    rgc_mode_e op_mode;
    integer seed = 4853;
    int n_mismatch = 0, n_compared = 0, i;
    int noms[4] = '{5, 4, 7, 8};

    // Short counts keep the run brief
    rgc_top #(.OTP_LOAD_CYCLES(20), .DELAY_STEP_CYCLES(10)) dut_u (.*);
    rgc_clk_src src_u (.run(clk_run), .clk_out(sync_clock_input));

    // 40 MHz core clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    // Sample 1 ns after the edge, once settled
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        #1;
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic pwm_exp(input logic fp, input logic [8:0] c);
        return fp || (c >= 9'(PWM_ENTRY_MA / LOAD_LSB_MA));
    endfunction : pwm_exp

    function automatic logic clk_ok(input int nom, input int f);
        return nom >= NOMINAL_MIN_MHZ && nom <= NOMINAL_MAX_MHZ
            && CLK_LOW_PCT * nom <= PCT_FULL * f
            && PCT_FULL * f <= CLK_HIGH_PCT * nom;
    endfunction : clk_ok

    task automatic wrap_up;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // Watchdog, about 3x the expected run
    initial begin
        cyc(20000);
        n_mismatch++;
        wrap_up();
    end

    // Main sequence
    initial begin
        {enable_pin, clk_run, buck_cfg_write, lin_cfg_write, buck_on_request,
         buck_pin_select, linreg_on_request, linreg_pin_select, dither_enable,
         sync_enable, ext_clock_nominal, meas_select_write, meas_select_buck,
         meas_done_mask, meas_done_clear, sync_clock_mask, sync_clock_clear,
         buck_cfg_data, lin_cfg_data, buck_load_code} = '0;
        srst = 1'b1;
        otp_buck_cfg = 44'({$random(seed), $random(seed)});
        otp_lin_cfg = 26'($random(seed));
        cyc(12);
        srst <= 1'b0;
        for (i = 0; i < 40 && op_mode !== ST_STANDBY; i++) cyc(1);
        chk(op_mode, ST_STANDBY);
        chk(buck_cfg, otp_buck_cfg);
        chk(lin_cfg, otp_lin_cfg);
        $display("power-up done");
        cyc(1);
        buck_cfg_data[0] <= '{vcode: 8'($random(seed)), fall: 4'hF,
                              default: '0};
        buck_cfg_write <= 2'h1;
        buck_on_request <= 2'h1;
        cyc(1);
        buck_cfg_write <= 2'h0;
        cyc(2);
        chk(buck_voltage_code[0], buck_cfg_data[0].vcode);
        chk(op_mode, ST_ACTIVE);
        cyc(1);
        buck_on_request <= 2'h0;
        cyc(2);
        chk(buck_on[0], 1'b0);
        chk(buck_voltage_code[0], 8'h00);
        // Mode table: light load, threshold code, forced PWM, random
        for (i = 0; i < 4; i++) begin
            cyc(1);
            buck_cfg_data[0].fpwm <= i[1];
            buck_load_code[0] <= (i == 3) ? 9'($random(seed))
                                          : 9'h01D + 9'(i[0]);
            buck_cfg_write <= 2'h1;
            buck_on_request <= 2'h3;
            cyc(1);
            buck_cfg_write <= 2'h0;
            cyc(3);
            chk(buck_pwm[0], pwm_exp(i[1], buck_load_code[0]));
        end
        $display("register enable done");
        code = 9'($random(seed));
        buck_load_code[1] <= code;
        meas_select_buck <= 1'b1;
        meas_select_write <= 1'b1;
        meas_done_mask <= 1'b1;
        cyc(1);
        meas_select_write <= 1'b0;
        for (i = 0; i < 2100 && meas_done_flag !== 1'b1; i++) cyc(1);
        chk(i <= MEAS_CYC + 2, 1'b1);
        chk(meas_buck, 1'b1);
        chk(meas_result_low, code[7:0]);
        chk(meas_result_high, {7'h00, code[8]});
        chk(meas_done_event, 1'b0);
        cyc(1);
        meas_done_mask <= 1'b0;
        meas_done_clear <= 1'b1;
        cyc(1);
        meas_done_clear <= 1'b0;
        cyc(1);
        chk(meas_done_flag, 1'b0);
        $display("measurement done");
        lin_cfg_data[0] <= '{vcode: 5'h0A, rise: 4'h3, fall: 4'h0};
        lin_cfg_write <= 2'h1;
        linreg_on_request <= 2'h1;
        linreg_pin_select <= 2'h1;
        cyc(1);
        lin_cfg_write <= 2'h0;
        cyc(8);
        chk(linreg_on[0], 1'b0);
        cyc(1);
        enable_pin <= 1'b1;
        for (i = 0; i < 45 && linreg_on[0] !== 1'b1; i++) cyc(1);
        chk(i >= 20 && i <= 38, 1'b1);
        cyc(2);
        chk(linreg_voltage_code[0], 5'h0A);
        enable_pin <= 1'b0;
        cyc(6);
        chk(linreg_on[0], 1'b0);
        $display("pin enable done");
        // Dither only with its bit set and sync off; ends with sync on
        for (i = 0; i < 4; i++) begin
            cyc(1);
            {dither_enable, sync_enable} <= 2'(i);
            cyc(2);
            chk(dither_active, i[1] & ~i[0]);
        end
        clk_run <= 1'b1;
        sync_clock_mask <= 1'b1;
        foreach (noms[k]) begin
            cyc(1);
            ext_clock_nominal <= 5'(noms[k]);
            cyc(1000);
            chk(ext_clock_valid, clk_ok(noms[k], 5));
            chk(ext_clock_selected, clk_ok(noms[k], 5));
        end
        chk(sync_clock_flag, 1'b1);
        chk(sync_clock_event, 1'b0);
        $display("sync clock done");
        wrap_up();
    end
endmodule : tb_regulator_enable_clock_control
